// *** src/rtcis_slave_port.sv ***
// Purpose: two-wire slave port reaching a 16-byte register space
// Assumes: clk at 10 MHz, far faster than the serial clock
// Notes:   scl, sda, select, halt and oscillator pins are synchronised
`timescale 1ns/1ps
`include "rtcis_defs.svh"

module rtcis_slave_port import rtcis_pkg::*; #(
  parameter int TIMEOUT_TICKS = `RTCIS_TIMEOUT_TICKS
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOeN,
  input  wire logic        addrSelectPin,
  input  wire logic        clockHalt,
  input  wire logic        oscIn,
  output logic [3:0]       readAddr,
  input  wire logic [7:0]  readData,
  output rtcis_user_t      userAccess
);

  logic [1:0]  rstSync;
  logic        rstN;
  rtcis_port_t c_reg;
  rtcis_port_t c_next;
  logic        sclRise;
  logic        sclFall;
  logic        startSeen;
  logic        stopSeen;
  logic        toClear;
  logic        toHold;
  logic        toExpired;

  // pointer step with wrap; used on every write and read byte
  function automatic logic [3:0] ptrNext(input logic [3:0] p);
    ptrNext = p + `RTCIS_PTR_STEP;
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // bus events, taken from the synchronised copies only
  assign sclRise   = c_reg.sclS && !c_reg.sclPrev;
  assign sclFall   = !c_reg.sclS && c_reg.sclPrev;
  assign startSeen = c_reg.sclS && c_reg.sclPrev && !c_reg.sdaS && c_reg.sdaPrev;
  assign stopSeen  = c_reg.sclS && c_reg.sclPrev && c_reg.sdaS && !c_reg.sdaPrev;

  // timeout window: fresh start, stop or expiry restart the count
  assign toClear = stopSeen || (startSeen && !c_reg.busy) || toExpired;
  assign toHold  = c_reg.haltS
                || (c_reg.st == ST_WDATA_ACK && c_reg.user.addr == `RTCIS_HOLD_REG);

  rtcis_timeout #(
    .TIMEOUT_TICKS (TIMEOUT_TICKS)
  ) u_timeout (
    .clk     (clk),
    .rstN    (rstN),
    .oscIn   (oscIn),
    .busy    (c_reg.busy),
    .clear   (toClear),
    .hold    (toHold),
    .expired (toExpired)
  );

  // protocol engine
  always_comb begin
    c_next               = c_reg;
    c_next.user.wrStrobe = 1'b0;
    c_next.user.rdStrobe = 1'b0;
    c_next.sclMeta       = sclIn;
    c_next.sclS          = c_reg.sclMeta;
    c_next.sclPrev       = c_reg.sclS;
    c_next.sdaMeta       = sdaIn;
    c_next.sdaS          = c_reg.sdaMeta;
    c_next.sdaPrev       = c_reg.sdaS;
    c_next.selMeta       = addrSelectPin;
    c_next.selS          = c_reg.selMeta;
    c_next.haltMeta      = clockHalt;
    c_next.haltS         = c_reg.haltMeta;
    if (toExpired) begin
      // drop the transfer; line released, so reads see ones until a new start
      c_next.st       = ST_IDLE;
      c_next.sdaDrive = 1'b0;
      c_next.busy     = 1'b0;
    end else if (startSeen) begin
      // start or repeated start; busy stays set across a repeat
      c_next.st       = ST_ADDR;
      c_next.cnt      = 4'h0;
      c_next.sdaDrive = 1'b0;
      c_next.busy     = 1'b1;
    end else if (stopSeen) begin
      // stop ends a held acknowledge, as do a start and the next falling clock
      c_next.st       = ST_IDLE;
      c_next.sdaDrive = 1'b0;
      c_next.busy     = 1'b0;
    end else if (sclRise) begin
      // receivers sample while clock is high
      if ((c_reg.st == ST_ADDR || c_reg.st == ST_REG || c_reg.st == ST_WDATA)
          && c_reg.cnt != `RTCIS_BITS_BYTE) begin
        c_next.shift = {c_reg.shift[6:0], c_reg.sdaS};
        c_next.cnt   = c_reg.cnt + 4'h1;
      end else if (c_reg.st == ST_RACK) begin
        c_next.ackd = !c_reg.sdaS;
      end
    end else if (sclFall) begin
      // drive changes other than the releases on expiry, start and stop happen just after a falling clock
      unique case (c_reg.st)
        ST_IDLE: begin
          c_next.st = ST_IDLE;
        end
        ST_ADDR: begin
          if (c_reg.cnt == `RTCIS_BITS_BYTE) begin
            if (c_reg.shift[7:1] == {`RTCIS_ADDR_FIXED, c_reg.selS}) begin
              c_next.rw       = c_reg.shift[0];
              c_next.st       = ST_ADDR_ACK;
              c_next.sdaDrive = 1'b1;
            end else begin
              c_next.st   = ST_IDLE;
              c_next.busy = 1'b0;
            end
          end
        end
        ST_REG: begin
          if (c_reg.cnt == `RTCIS_BITS_BYTE) begin
            c_next.ptr      = c_reg.shift[3:0]; // upper nibble ignored, 16 registers
            c_next.st       = ST_REG_ACK;
            c_next.sdaDrive = 1'b1;
          end
        end
        ST_WDATA: begin
          if (c_reg.cnt == `RTCIS_BITS_BYTE) begin
            c_next.user.addr     = c_reg.ptr;
            c_next.user.wrData   = c_reg.shift;
            c_next.user.wrStrobe = 1'b1;
            c_next.ptr           = ptrNext(c_reg.ptr);
            c_next.st            = ST_WDATA_ACK;
            c_next.sdaDrive      = 1'b1;
          end
        end
        ST_ADDR_ACK: begin
          c_next.cnt = 4'h0;
          if (c_reg.rw) begin
            // current pointer already sits one past the last access
            c_next.shift         = readData;
            c_next.user.addr     = c_reg.ptr;
            c_next.user.rdStrobe = 1'b1;
            c_next.ptr           = ptrNext(c_reg.ptr);
            c_next.sdaDrive      = !readData[7];
            c_next.st            = ST_RDATA;
          end else begin
            c_next.sdaDrive = 1'b0;
            c_next.st       = ST_REG;
          end
        end
        ST_REG_ACK, ST_WDATA_ACK: begin
          // ninth falling clock ends a held acknowledge too
          c_next.cnt      = 4'h0;
          c_next.sdaDrive = 1'b0;
          c_next.st       = ST_WDATA;
        end
        ST_RDATA: begin
          c_next.shift = {c_reg.shift[6:0], 1'b1};
          c_next.cnt   = c_reg.cnt + 4'h1;
          if (c_reg.cnt == `RTCIS_BIT_LAST) begin
            c_next.sdaDrive = 1'b0;
            c_next.ackd     = 1'b0;
            c_next.st       = ST_RACK;
          end else begin
            c_next.sdaDrive = !c_reg.shift[6];
          end
        end
        ST_RACK: begin
          c_next.cnt = 4'h0;
          if (c_reg.ackd) begin
            c_next.shift         = readData;
            c_next.user.addr     = c_reg.ptr;
            c_next.user.rdStrobe = 1'b1;
            c_next.ptr           = ptrNext(c_reg.ptr);
            c_next.sdaDrive      = !readData[7];
            c_next.st            = ST_RDATA;
          end else begin
            c_next.sdaDrive = 1'b0;
            c_next.st       = ST_IDLE;
          end
        end
        default: begin
          c_next.st       = ST_IDLE;
          c_next.sdaDrive = 1'b0;
        end
      endcase
    end
  end

  // idle lines read high, so the scl and sda sync flops reset high
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      c_reg          <= '0;
      c_reg.sclMeta  <= 1'b1;
      c_reg.sclS     <= 1'b1;
      c_reg.sclPrev  <= 1'b1;
      c_reg.sdaMeta  <= 1'b1;
      c_reg.sdaS     <= 1'b1;
      c_reg.sdaPrev  <= 1'b1;
      c_reg.st       <= ST_IDLE;
    end else begin
      c_reg <= c_next;
    end
  end

  // open drain: output level fixed low, enable low while pulling
  assign sdaOut     = 1'b0;
  assign sdaOeN     = !c_reg.sdaDrive;
  assign readAddr   = c_reg.ptr;
  assign userAccess = c_reg.user;

  sequence sAddrByteDone;
    c_reg.st == ST_ADDR && sclFall && !toExpired && !startSeen && !stopSeen
      && c_reg.cnt == `RTCIS_BITS_BYTE;
  endsequence

  sequence sDriveAck;
    c_reg.st == ST_ADDR_ACK && !sdaOeN;
  endsequence

  a_addr_match: assert property (@(posedge clk) disable iff (!rstN)
    sAddrByteDone and (c_reg.shift[7:1] == {`RTCIS_ADDR_FIXED, c_reg.selS}) |=> sDriveAck)
    else $error("matching address not acknowledged");

  a_addr_ignore: assert property (@(posedge clk) disable iff (!rstN)
    sAddrByteDone and (c_reg.shift[7:1] != {`RTCIS_ADDR_FIXED, c_reg.selS})
      |=> c_reg.st == ST_IDLE && sdaOeN)
    else $error("foreign address answered");

  a_dir_bit: assert property (@(posedge clk) disable iff (!rstN)
    sAddrByteDone |=> c_reg.rw == $past(c_reg.shift[0]) || c_reg.st == ST_IDLE)
    else $error("direction bit not taken from bit 0");

  a_write_incr: assert property (@(posedge clk) disable iff (!rstN)
    c_reg.user.wrStrobe |-> c_reg.ptr == ptrNext(c_reg.user.addr)
      && c_reg.st == ST_WDATA_ACK && !sdaOeN)
    else $error("write pointer not advanced by one");

  a_read_next: assert property (@(posedge clk) disable iff (!rstN)
    c_reg.st == ST_RACK && sclFall && c_reg.ackd && !toExpired && !startSeen && !stopSeen
      |=> c_reg.user.rdStrobe && c_reg.user.addr == $past(c_reg.ptr) && c_reg.st == ST_RDATA)
    else $error("next read byte not fetched");

  a_timeout_idle: assert property (@(posedge clk) disable iff (!rstN)
    toExpired |=> c_reg.st == ST_IDLE && sdaOeN && !c_reg.busy)
    else $error("timeout did not release the bus");

  a_restart_keep: assert property (@(posedge clk) disable iff (!rstN)
    startSeen && c_reg.busy && !toExpired |-> !toClear ##1 c_reg.busy)
    else $error("repeated start restarted the timeout");

  a_halt_hold: assert property (@(posedge clk) disable iff (!rstN)
    c_reg.st == ST_WDATA_ACK && c_reg.user.addr == `RTCIS_HOLD_REG |-> !toExpired)
    else $error("timeout acted during register zero acknowledge");

  a_halt_bit: assert property (@(posedge clk) disable iff (!rstN)
    c_reg.haltS |-> !toExpired)
    else $error("timeout acted while clock halted");

  a_drive_low: assert property (@(posedge clk) disable iff (!rstN)
    $changed(sdaOeN) && !$past(toExpired) && !$past(startSeen) && !$past(stopSeen)
      |-> !c_reg.sclS)
    else $error("data line changed while clock high");

endmodule

// *** src/rtcis_defs.svh ***
// Purpose: constants of the two-wire slave port of the clock module
// Assumes: included by bare name from design files
// Notes:   numbers only, no logic
`ifndef RTCIS_DEFS_SVH
`define RTCIS_DEFS_SVH

// fixed upper six bits of the slave address: 1010 then 00
`define RTCIS_ADDR_FIXED   6'h28
// bits per byte, compared against the bit counter
`define RTCIS_BITS_BYTE    4'h8
// last bit index while shifting a byte out
`define RTCIS_BIT_LAST     4'h7
// register whose write acknowledge is never timed out
`define RTCIS_HOLD_REG     4'h0
// pointer step during auto-increment
`define RTCIS_PTR_STEP     4'h1
// bus timeout: time in milliseconds and oscillator rate in hertz
`define RTCIS_TIMEOUT_MS   1000
`define RTCIS_OSC_HZ       32768
`define RTCIS_TIMEOUT_TICKS ((`RTCIS_OSC_HZ * `RTCIS_TIMEOUT_MS) / 1000)
// width of the timeout counter
`define RTCIS_TO_CNT_W     17

`endif

// *** src/rtcis_pkg.sv ***
// Purpose: types shared by the slave port and its timeout counter
// Assumes: counter width matches the header
// Notes:   state of every module is one packed struct, except the port's two-flop reset synchroniser
package rtcis_pkg;

  // protocol states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_REG       = 9'h008,
    ST_REG_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RACK      = 9'h100
  } rtcis_state_t;

  // user-side access bundle
  typedef struct packed {
    logic       wrStrobe;
    logic       rdStrobe;
    logic [3:0] addr;
    logic [7:0] wrData;
  } rtcis_user_t;

  // complete state of the protocol engine
  typedef struct packed {
    logic         sclMeta;
    logic         sclS;
    logic         sclPrev;
    logic         sdaMeta;
    logic         sdaS;
    logic         sdaPrev;
    logic         selMeta;
    logic         selS;
    logic         haltMeta;
    logic         haltS;
    rtcis_state_t st;
    logic [3:0]   cnt;
    logic [7:0]   shift;
    logic [3:0]   ptr;
    logic         rw;
    logic         ackd;
    logic         busy;
    logic         sdaDrive;
    rtcis_user_t  user;
  } rtcis_port_t;

  // state of the timeout counter
  typedef struct packed {
    logic        oscMeta;
    logic        oscS;
    logic        oscPrev;
    logic [16:0] count;
  } rtcis_to_t;

endpackage

// *** src/rtcis_timeout.sv ***
// Purpose: one-second bus timeout timed by the 32.768 kHz oscillator
// Assumes: clear pulses come from the port on the same clock
// Notes:   oscillator input is a pin, synchronised before use
`timescale 1ns/1ps
`include "rtcis_defs.svh"

module rtcis_timeout import rtcis_pkg::*; #(
  parameter int TIMEOUT_TICKS = `RTCIS_TIMEOUT_TICKS
) (
  input  wire logic clk,
  input  wire logic rstN,
  input  wire logic oscIn,
  input  wire logic busy,
  input  wire logic clear,
  input  wire logic hold,
  output logic      expired
);

  rtcis_to_t cur_reg;
  rtcis_to_t cur_next;

  localparam logic [16:0] TICKS = 17'(TIMEOUT_TICKS);

  // count oscillator rising edges while a transaction is open
  always_comb begin
    cur_next         = cur_reg;
    cur_next.oscMeta = oscIn;
    cur_next.oscS    = cur_reg.oscMeta;
    cur_next.oscPrev = cur_reg.oscS;
    if (clear) begin
      cur_next.count = 17'h00000;
    end else if (busy && cur_reg.oscS && !cur_reg.oscPrev && cur_reg.count != TICKS) begin
      cur_next.count = cur_reg.count + 17'h00001; // saturates, so a held ack never wraps
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // hold masks firing but not counting; release after a long hold fires at once
  assign expired = busy && (cur_reg.count == TICKS) && !hold;

endmodule

// *** dv/rtcis_master.sv ***
// Purpose: behavioural two-wire bus master facing the slave port
// Assumes: bench clock of 100 ns, one serial quarter is two cycles
// Notes:   drives open-drain levels, 1 releases the line
`timescale 1ns/1ps
module rtcis_master (
  input  wire logic clk,
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaOut
);
  int lowQ = 1; // extra low quarters make a slow master

  // both lines released at time zero
  initial begin
    sclOut = 1'b1;
    sdaOut = 1'b1;
  end

  task automatic q();
    repeat (2) @(negedge clk);
  endtask

  // one bit; data moves only while the clock is low
  task automatic xbit(input logic b, output logic s);
    sclOut = 1'b0;
    repeat (lowQ) q();
    sdaOut = b; // only ever pulls low
    q();
    sclOut = 1'b1;
    q();
    s = sdaLine;
    q();
  endtask

  // fresh or repeated start, no stop needed before it
  task automatic start();
    sclOut = 1'b0;
    q();
    sdaOut = 1'b1;
    q();
    sclOut = 1'b1;
    q();
    sdaOut = 1'b0;
    q();
  endtask

  // stop, with bus free time before the next start
  task automatic stop();
    sclOut = 1'b0;
    q();
    sdaOut = 1'b0;
    q();
    sclOut = 1'b1;
    q();
    sdaOut = 1'b1;
    repeat (4) q();
  endtask

  // byte out msb first, acknowledge may be held for stall cycles
  task automatic wbyte(input logic [7:0] d, input int stall, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], s);
    sclOut = 1'b0;
    repeat (stall) @(negedge clk);
    xbit(1'b1, s); // ninth pulse ends a held acknowledge
    ack = ~s;
  endtask

  // byte in; last wanted byte left unacknowledged
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, s);
      d[i] = s;
    end
    xbit(~more, s);
  endtask
endmodule

// *** dv/rtc_i2c_slave_port_test.sv ***
// Purpose: self-checking bench of the two-wire slave port
// Assumes: timeout shortened to 8 oscillator ticks
// Notes:   register space lives here; reference model is mdl and ptr
`timescale 1ns/1ps
module rtc_i2c_slave_port_test import rtcis_pkg::*; ;
  logic        clk = 1'b0;
  logic        resetN = 1'b0;
  logic        sclM;
  logic        sdaM;
  logic        sdaOut;
  logic        sdaOeN;
  logic        sdaLine;
  logic        sel = 1'b0;
  logic        halt = 1'b0;
  logic        osc = 1'b0;
  logic [3:0]  readAddr;
  logic [7:0]  readData;
  logic [7:0]  regs [16];
  rtcis_user_t userAccess;
  logic [31:0] seed = 32'h0000001e;
  int          mdl [16];
  int          ptr = 0;
  int          errors = 0;
  int          compares = 0;
  int          rdSeen = 0;
  int          cyc = 0;

  // system clock and a free-running oscillator moved on falling edges
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    forever begin
      #15200;
      @(negedge clk) osc = ~osc;
    end
  end

  // wired-and data line with pull-up
  assign sdaLine = sdaM & (sdaOeN | sdaOut);
  assign readData = regs[readAddr];

  // register space follows the write strobe
  always @(posedge clk) begin
    if (userAccess.wrStrobe === 1'b1) begin
      regs[userAccess.addr] <= userAccess.wrData;
    end
    // one fetch per byte the port loads for sending
    if (userAccess.rdStrobe === 1'b1) begin
      rdSeen <= rdSeen + 1;
    end
  end

  // watchdog: a hung bus ends the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      summarize();
    end
  end

  rtcis_slave_port #(.TIMEOUT_TICKS(8)) i_rtcis_slave_port (
    .clk          (clk),
    .reset_n      (resetN),
    .sclIn        (sclM),
    .sdaIn        (sdaLine),
    .sdaOut       (sdaOut),
    .sdaOeN       (sdaOeN),
    .addrSelectPin(sel),
    .clockHalt    (halt),
    .oscIn        (osc),
    .readAddr     (readAddr),
    .readData     (readData),
    .userAccess   (userAccess)
  );

  rtcis_master i_rtcis_master (
    .clk    (clk),
    .sdaLine(sdaLine),
    .sclOut (sclM),
    .sdaOut (sdaM)
  );

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // start plus slave address with direction
  task automatic head(input logic rw, input int stall, input logic expAck);
    logic a;
    i_rtcis_master.start();
    i_rtcis_master.wbyte({6'h28, sel, rw}, stall, a);
    check({7'h00, a}, {7'h00, expAck});
  endtask

  // pointer write
  task automatic setp(input logic [3:0] r, input int stall);
    logic a;
    head(1'b0, 0, 1'b1);
    i_rtcis_master.wbyte({4'h0, r}, stall, a);
    check({7'h00, a}, 8'h01);
    ptr = r;
  endtask

  // burst write of n random bytes
  task automatic wr(input logic [3:0] r, input int n, input int stall);
    logic       a;
    logic [7:0] d;
    setp(r, 0);
    for (int i = 0; i < n; i++) begin
      d = rnd();
      i_rtcis_master.wbyte(d, stall, a);
      check({7'h00, a}, 8'h01);
      mdl[ptr] = d;
      ptr = (ptr + 1) % 16;
    end
    i_rtcis_master.stop();
  endtask

  // random read from r, or current read when r is negative
  task automatic rd(input int r, input int n, input int stall, input logic live);
    logic [7:0] d;
    int         base;
    base = rdSeen;
    if (r >= 0) begin
      setp(r[3:0], stall);
    end
    head(1'b1, stall, live);
    for (int i = 0; i < n; i++) begin
      i_rtcis_master.rbyte(i < n - 1, d);
      check(d, live ? 8'(mdl[ptr]) : 8'hff);
      if (live) begin
        ptr = (ptr + 1) % 16;
      end
    end
    i_rtcis_master.stop();
    check(8'(rdSeen - base), live ? 8'(n) : 8'h00);
  endtask

  initial begin
    logic [6:0] a;
    logic       ack;
    logic [7:0] d;
    for (int i = 0; i < 16; i++) begin
      regs[i] = rnd();
      mdl[i] = regs[i];
    end
    repeat (4) @(negedge clk);
    resetN = 1'b1;
    repeat (8) @(negedge clk);
    // every single-bit corruption of the address is ignored
    for (int p = 0; p < 2; p++) begin
      sel = p[0];
      repeat (4) @(negedge clk);
      for (int k = 0; k < 8; k++) begin
        a = {6'h28, sel};
        if (k > 0) begin
          a[k - 1] = ~a[k - 1];
        end
        i_rtcis_master.start();
        i_rtcis_master.wbyte({a, 1'b0}, 0, ack);
        check({7'h00, ack}, {7'h00, k == 0});
        i_rtcis_master.stop();
      end
    end
    wr(4'hf, 3, 0);
    wr(4'h0, 1, 3000); // held acknowledge outlives the timeout
    // plain write stalled past the timeout: the byte already taken lands,
    // the byte after the expiry is dropped and nothing acknowledges
    setp(4'h3, 0);
    d = rnd();
    i_rtcis_master.wbyte(d, 2600, ack);
    check({7'h00, ack}, 8'h00);
    mdl[3] = d;
    i_rtcis_master.wbyte(~d, 0, ack);
    check({7'h00, ack}, 8'h00);
    i_rtcis_master.stop();
    rd(3, 2, 0, 1'b1);
    rd(14, 4, 0, 1'b1);
    i_rtcis_master.lowQ = 3;
    rd(-1, 2, 0, 1'b1);
    i_rtcis_master.lowQ = 1;
    rd(5, 1, 1600, 1'b0); // two short stalls across a repeated start
    halt = 1'b1;
    rd(5, 2, 1600, 1'b1);
    halt = 1'b0;
    summarize();
  end
endmodule
